// File: src/hpc_map.svh
// offsets, field positions, reset values and counts of the hot-plug strap and input block
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH
`define HPC_CTRL_OFF 8'h00
`define HPC_STAT_OFF 8'h04
`define HPC_CTRL_RST 12'h000
`define HPC_CTRL_W 12
`define HPC_F_PWREN 0
`define HPC_F_CLKEN 2
`define HPC_F_BUSEN 4
`define HPC_F_SLRST 6
`define HPC_F_PLED 8
`define HPC_F_ALED 10
`define HPC_CLK_LSB 6'd1
`define HPC_CLK_MSB 6'd2
`define HPC_CLK_RSV 6'd3
`define HPC_CLK_LAST 6'd47
`define HPC_CH_INT 2'h0
`define HPC_CH_NINT 2'h1
`define HPC_CH_DIAG1 2'h2
`define HPC_CH_DIAG2 2'h3
`define HPC_SYNC_W 25
`define HPC_HTRANS_NONSEQ 2'h2
`define HPC_HTRANS_SEQ 2'h3
`endif

// File: src/hpc_pkg.sv
// types of the hot-plug strap and input block
package hpc_pkg;
  typedef enum logic [2:0] {MODE_OFF, MODE_OPER, MODE_NAND, MODE_TRI, MODE_RSVD} hpc_mode_t;
  typedef enum logic [1:0] {SER_IDLE, SER_ADDR, SER_SHIFT} hpc_ser_t;
endpackage : hpc_pkg

// File: src/hpc_strap_sin.sv
// power-on mode strapping and serial input status channels of a dual-slot hot-plug controller
// What this block does
// (RQ1) at power-good rise, test 0 and both mode straps 1 give operational mode
// (RQ2) test 1 at rise: straps 00 give NAND tree, high 0 low 1 tri-state
// (RQ3) straps are read from the shared serial pins only at power-good rise
// (RQ4) power-good high with test 1: indicators show power enable and combined fault, except in tri-state mode where both are driven low
// (RQ5) operational mode lets one controller reach cascaded devices over four channel groups
// (RQ6) controller sends start low, address LSB, MSB, reserved, then holds line high to 47
// (RQ7) channel address 00 interrupt, 01 non-interrupt, 10 diagnostic one, 11 diagnostic two
// (RQ8) cascade input data shifts through this device toward its serial data-out pin
// (RQ9) channel 00 bits 0/8 interlock open, 3/11 and 4/12 presence, 5-7 reserved
// (RQ10) channel 00 bits 1 and 9 report attention button pushed
// (RQ11) channel 00 bits 2 and 10 report combined main and aux supply fault
// (RQ12) channel 01 bits 0-3 and 8-11: M66EN, cap1, cap2, aux fault
// (RQ13) stream bits beyond 15 carry downstream slot bytes from the cascade input
// (RQ14) boards must not strap reserved combinations; their behaviour is undefined
// (RQ15) capability pin: grounded 00, pull-down 01, open 11
// (RQ16) latched mode straps read back per slot in diagnostic channel two
// (RQ17) serial interface runs only while power-good is asserted
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "hpc_map.svh"
module hpc_strap_sin (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // power and straps
  input wire logic main_power_valid,
  input wire logic test_strap,
  // shared strap / serial pins
  input wire logic serial_out_chain_output_i,
  output logic serial_out_chain_output_o,
  output logic serial_out_chain_output_oe,
  input wire logic serial_in_chain_output_i,
  output logic serial_in_chain_output_o,
  output logic serial_in_chain_output_oe,
  // serial input link
  input wire logic serial_input_clock,
  input wire logic channel_select_line,
  input wire logic serial_in_cascade_input,
  // slot inputs, index 0 slot A, 1 slot B
  input wire logic [1:0] interlock_contact,
  input wire logic [1:0] button_pushed,
  input wire logic [1:0] main_supply_fault,
  input wire logic [1:0] aux_supply_fault,
  input wire logic [1:0] present2,
  input wire logic [1:0] present1,
  input wire logic [1:0] m66_enable,
  input wire logic [1:0] cap_level_a,
  input wire logic [1:0] cap_level_b,
  // indicators
  output logic [1:0] power_indicator,
  output logic [1:0] attention_indicator
);

  // capability pin level 0 grounded, 1 pull-down, 2 or 3 open
  function automatic logic [1:0] cap_decode(input logic [1:0] lvl);
    logic [1:0] c;
    c = 2'h0;
    unique case (lvl)
      2'h0: c = 2'h0;
      2'h1: c = 2'h1;
      2'h2, 2'h3: c = 2'h3;
    endcase
    return c; // see (RQ15)
  endfunction : cap_decode

  // status byte of one slot for the chosen channel
  // slot vector: [8] present1 [7] present2 [6] interlock [5] button [4] main fault [3] aux fault
  // [2] m66 enable, [1:0] capability pin level
  function automatic logic [7:0] slot_byte(input logic [1:0] ch, input logic [8:0] s, input logic [5:0] st,
                                           input logic [1:0] straps);
    logic [7:0] b;
    b = 8'h00;
    unique case (ch)
      `HPC_CH_INT: b = {3'h0, s[8], s[7], s[4] | s[3], s[5], s[6]}; // see (RQ9) (RQ10) (RQ11)
      `HPC_CH_NINT: b = {4'h0, s[3], cap_decode(s[1:0]), s[2]}; // see (RQ12)
      `HPC_CH_DIAG1: b = {1'b0, st, 1'b1};
      `HPC_CH_DIAG2: b = {5'h00, 1'b1, straps}; // see (RQ16)
    endcase
    return b;
  endfunction : slot_byte

  // per slot: present1, present2, interlock, button, main fault, aux fault, m66, capability level
  // two-flop synchronisers for every pin input
  logic [`HPC_SYNC_W-1:0] sync1_reg;
  logic [`HPC_SYNC_W-1:0] sync2_reg;
  logic [`HPC_SYNC_W-1:0] raw_in;
  assign raw_in = {main_power_valid, test_strap, serial_out_chain_output_i, serial_in_chain_output_i,
                   serial_input_clock, channel_select_line, serial_in_cascade_input,
                   present1[1], present2[1], interlock_contact[1], button_pushed[1], main_supply_fault[1],
                   aux_supply_fault[1], m66_enable[1], cap_level_b,
                   present1[0], present2[0], interlock_contact[0], button_pushed[0], main_supply_fault[0],
                   aux_supply_fault[0], m66_enable[0], cap_level_a};
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic pg_s, test_s, strap_hi_s, strap_lo_s, sic_s, sil_s, serial_in_cascade_input_s;
  logic [8:0] slot_a, slot_b;
  assign {pg_s, test_s, strap_hi_s, strap_lo_s, sic_s, sil_s, serial_in_cascade_input_s} = sync2_reg[24:18];
  assign slot_b = sync2_reg[17:9];
  assign slot_a = sync2_reg[8:0];

  // ahb-lite register slave, zero wait states
  // a read right behind a write to ctrl returns the old value; the write lands a cycle later
  logic [`HPC_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] status_word;
  logic take;
  assign take = hsel && hready && (htrans == `HPC_HTRANS_NONSEQ || htrans == `HPC_HTRANS_SEQ);

  // serial and mode state
  hpc_pkg::hpc_mode_t mode_reg, mode_next;
  hpc_pkg::hpc_ser_t ser_reg, ser_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [1:0] ch_reg, ch_next;
  logic [1:0] straps_reg, straps_next;
  logic [15:0] shift_reg, shift_next;
  logic pg_d_reg, sic_d_reg, test_at_rise_reg, test_at_rise_next;
  logic sic_rise, pg_rise, ser_on;
  assign sic_rise = sic_s && !sic_d_reg;
  assign pg_rise = pg_s && !pg_d_reg;
  // link logic is held idle outside operational mode, so test modes never shift
  assign ser_on = pg_s && (mode_reg == hpc_pkg::MODE_OPER); // see (RQ17) (RQ5)

  assign status_word = {22'h000000, test_at_rise_reg, ser_reg != hpc_pkg::SER_IDLE, ch_reg, straps_reg,
                        1'b0, mode_reg};

  always_comb begin
    ctrl_next = ctrl_reg;
    wr_pend_next = take && hwrite;
    wr_addr_next = haddr[7:0];
    rdata_next = rdata_reg;
    if (wr_pend_reg && wr_addr_reg == `HPC_CTRL_OFF) begin
      ctrl_next = hwdata[`HPC_CTRL_W-1:0];
    end
    if (take && !hwrite) begin
      unique case (haddr[7:0])
        `HPC_CTRL_OFF: rdata_next = {20'h00000, ctrl_reg};
        `HPC_STAT_OFF: rdata_next = status_word;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `HPC_CTRL_RST;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // per-slot state for diagnostic one: pwren, clken, busen, reset, power led, attention led
  logic [5:0] state_a, state_b;
  assign state_a = {attention_indicator[0], power_indicator[0], ctrl_reg[`HPC_F_SLRST], ctrl_reg[`HPC_F_BUSEN],
                    ctrl_reg[`HPC_F_CLKEN], ctrl_reg[`HPC_F_PWREN]};
  assign state_b = {attention_indicator[1], power_indicator[1], ctrl_reg[`HPC_F_SLRST+1],
                    ctrl_reg[`HPC_F_BUSEN+1], ctrl_reg[`HPC_F_CLKEN+1], ctrl_reg[`HPC_F_PWREN+1]};

  always_comb begin
    mode_next = mode_reg;
    straps_next = straps_reg;
    test_at_rise_next = test_at_rise_reg;
    ser_next = ser_reg;
    cnt_next = cnt_reg;
    ch_next = ch_reg;
    shift_next = shift_reg;
    if (pg_rise) begin
      // straps sampled only here; afterwards those pins carry serial data
      straps_next = {strap_hi_s, strap_lo_s}; // see (RQ3)
      test_at_rise_next = test_s;
      if (!test_s && strap_hi_s && strap_lo_s) begin
        mode_next = hpc_pkg::MODE_OPER; // see (RQ1)
      end else if (test_s && !strap_hi_s) begin
        mode_next = strap_lo_s ? hpc_pkg::MODE_TRI : hpc_pkg::MODE_NAND; // see (RQ2)
      end else begin
        mode_next = hpc_pkg::MODE_RSVD; // see (RQ14)
      end
    end else if (!pg_s) begin
      mode_next = hpc_pkg::MODE_OFF;
    end
    if (!ser_on) begin
      ser_next = hpc_pkg::SER_IDLE;
      cnt_next = 6'd0;
    end else if (sic_rise) begin
      // cascade data enters at the top and leaves through bit 0
      shift_next = {serial_in_cascade_input_s, shift_reg[15:1]}; // see (RQ8) (RQ13)
      cnt_next = cnt_reg + 6'd1;
      unique case (ser_reg)
        hpc_pkg::SER_IDLE: begin
          if (!sil_s) begin
            ser_next = hpc_pkg::SER_ADDR; // see (RQ6)
            cnt_next = 6'd0;
          end
        end
        hpc_pkg::SER_ADDR: begin
          if (cnt_next == `HPC_CLK_LSB) begin
            ch_next[0] = sil_s;
          end
          if (cnt_next == `HPC_CLK_MSB) begin
            ch_next[1] = sil_s;
          end
          if (cnt_next == `HPC_CLK_RSV) begin
            shift_next = {slot_byte(ch_reg, slot_b, state_b, straps_reg),
                          slot_byte(ch_reg, slot_a, state_a, straps_reg)}; // see (RQ7)
            ser_next = hpc_pkg::SER_SHIFT;
          end
        end
        hpc_pkg::SER_SHIFT: begin
          // leave on the last clock itself so the very next rise may carry a new start bit
          if (cnt_next == `HPC_CLK_LAST) begin
            ser_next = hpc_pkg::SER_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_reg <= hpc_pkg::MODE_OFF;
      straps_reg <= 2'h0;
      test_at_rise_reg <= 1'b0;
      ser_reg <= hpc_pkg::SER_IDLE;
      cnt_reg <= 6'd0;
      ch_reg <= 2'h0;
      shift_reg <= 16'h0000;
      pg_d_reg <= 1'b0;
      sic_d_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      straps_reg <= straps_next;
      test_at_rise_reg <= test_at_rise_next;
      ser_reg <= ser_next;
      cnt_reg <= cnt_next;
      ch_reg <= ch_next;
      shift_reg <= shift_next;
      pg_d_reg <= pg_s;
      sic_d_reg <= sic_s;
    end
  end

  // pin and indicator drive
  logic nand_out;
  logic [1:0] comb_fault, pled, aled;
  // nand tree spans every synced slot input plus the channel select and cascade inputs, not the link clock
  assign nand_out = ~&{slot_a, slot_b, sil_s, serial_in_cascade_input_s};
  assign comb_fault = {slot_b[4] | slot_b[3], slot_a[4] | slot_a[3]};

  always_comb begin
    pled = {ctrl_reg[`HPC_F_PLED+1], ctrl_reg[`HPC_F_PLED]};
    aled = {ctrl_reg[`HPC_F_ALED+1], ctrl_reg[`HPC_F_ALED]};
    // test strap is read live here, not the value latched at power-good rise
    if (pg_s && test_s) begin
      pled = {ctrl_reg[`HPC_F_PWREN+1], ctrl_reg[`HPC_F_PWREN]}; // see (RQ4)
      aled = comb_fault; // see (RQ4)
    end
    if (mode_reg == hpc_pkg::MODE_TRI) begin
      pled = 2'h0;
      aled = 2'h0;
    end
  end

  assign power_indicator = pled;
  assign attention_indicator = aled;
  assign serial_in_chain_output_o = (mode_reg == hpc_pkg::MODE_NAND) ? nand_out : shift_reg[0];
  assign serial_in_chain_output_oe = ser_on || (pg_s && mode_reg == hpc_pkg::MODE_NAND);
  assign serial_out_chain_output_o = 1'b0;
  assign serial_out_chain_output_oe = 1'b0;

endmodule : hpc_strap_sin

// File: sim/hpc_strap_sin_asserts.sv
// assertion checker bound to the hot-plug strap and input block
`timescale 1ns/100ps
module hpc_chk (
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // power, straps and pins
  input wire logic main_power_valid,
  input wire logic test_strap,
  input wire logic serial_in_chain_output_oe,
  input wire logic serial_out_chain_output_oe,
  input wire logic [1:0] main_supply_fault,
  input wire logic [1:0] aux_supply_fault,
  input wire logic [1:0] attention_indicator
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not zero-wait OKAY");
  a_rdata_holds: assert property (!$past(hsel && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_link_unpowered: assert property (!main_power_valid [*4] |-> !serial_in_chain_output_oe)
    else $error("serial out driven without power");
  a_link_drops: assert property ($fell(main_power_valid) |-> ##[1:5] !serial_in_chain_output_oe)
    else $error("serial out not released");
  a_oper_entry: assert property ($rose(serial_in_chain_output_oe) |-> main_power_valid)
    else $error("serial out enabled without power");
  a_mode_held: assert property (main_power_valid [*8] |-> $stable(serial_in_chain_output_oe))
    else $error("mode changed while powered");
  a_fault_shown: assert property (
    (main_power_valid && test_strap && serial_in_chain_output_oe && $stable({main_supply_fault, aux_supply_fault}))
    [*4] |-> attention_indicator == (main_supply_fault | aux_supply_fault)) else $error("attention not fault");
  a_out_idle: assert property (!serial_out_chain_output_oe) else $error("output chain pin driven");
  c_oper: cover property ($rose(serial_in_chain_output_oe));
  c_pg_fall: cover property ($fell(main_power_valid));
  c_att: cover property (attention_indicator != 2'h0);
endmodule : hpc_chk
bind hpc_strap_sin hpc_chk u_chk (.*);

// File: sim/hpc_ctl_model.sv
// behavioural model of the system hot-plug controller on the serial input link
`timescale 1ns/100ps
module hpc_ctl_model (
  // link to the device
  output logic link_clk,
  output logic sel,
  output logic casc,
  input wire logic din
);
  initial begin
    link_clk = 1'b0;
    sel = 1'b1;
    casc = 1'b0;
  end
  // one 48-clock frame, link clock still between frames
  task automatic frame(input logic [1:0] ch, input logic [15:0] cd, input int hp, output logic [31:0] got);
    #7;
    for (int n = 0; n < 48; n++) begin
      sel = (n == 0) ? 1'b0 : (n == 1) ? ch[0] : (n == 2) ? ch[1] : 1'b1;
      casc = (n >= 4 && n < 20) ? cd[n-4] : ~casc;
      #hp link_clk = 1'b1;
      if (n >= 4 && n < 36) got[n-4] = din;
      #hp link_clk = 1'b0;
    end
  endtask : frame
endmodule : hpc_ctl_model

// File: sim/hpc_strap_sin_tb_top.sv
// self-checking bench of the hot-plug strap and input block
`timescale 1ns/100ps
`include "hpc_map.svh"
module hpc_strap_sin_tb_top;
  logic ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, pg = 1'b0, tst = 1'b0, s_hi = 1'b1, s_lo = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, got;
  logic hreadyout, hresp, so_o, so_oe, si_o, si_oe, lclk, sel, casc;
  logic [1:0] ic = 2'h1, bp = 2'h2, mf = 2'h1, af = 2'h0, p2 = 2'h2, p1 = 2'h1, m66 = 2'h2, pwi, att;
  logic [11:0] ctrl = 12'h5A6;
  logic [2:0] tab [4] = '{3'b110, 3'b100, 3'b101, 3'b011};
  logic [2:0] mexp [4] = '{3'h4, 3'h2, 3'h3, 3'h1};
  int num_errors = 0, n_checks = 0;
  wire si_pin = si_oe ? si_o : s_lo;
  wire so_pin = so_oe ? so_o : s_hi;
  always #12.5 ref_clk = ~ref_clk;
  hpc_strap_sin dut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .main_power_valid(pg), .test_strap(tst), .serial_out_chain_output_i(so_pin),
    .serial_out_chain_output_o(so_o), .serial_out_chain_output_oe(so_oe), .serial_in_chain_output_i(si_pin),
    .serial_in_chain_output_o(si_o), .serial_in_chain_output_oe(si_oe), .serial_input_clock(lclk),
    .channel_select_line(sel), .serial_in_cascade_input(casc), .interlock_contact(ic), .button_pushed(bp),
    .main_supply_fault(mf), .aux_supply_fault(af), .present2(p2), .present1(p1), .m66_enable(m66),
    .cap_level_a(2'h1), .cap_level_b(2'h3), .power_indicator(pwi), .attention_indicator(att));
  hpc_ctl_model mdl (.link_clk(lclk), .sel(sel), .casc(casc), .din(si_pin));
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
    int k = 0;
    @(posedge ref_clk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= `HPC_HTRANS_NONSEQ;
    do begin @(posedge ref_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do begin @(posedge ref_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    r = hrdata;
    if (k >= 50) begin
      num_errors++;
      summarize();
    end
  endtask : ahb
  // power cycle with new straps; straps move again once the mode is taken
  task automatic pcyc(input logic t, h, l);
    pg <= 1'b0;
    repeat (6) @(posedge ref_clk);
    tst <= t; s_hi <= h; s_lo <= l;
    repeat (4) @(posedge ref_clk);
    pg <= 1'b1;
    repeat (8) @(posedge ref_clk);
    s_hi <= ~h; s_lo <= ~l;
    repeat (2) @(posedge ref_clk);
  endtask : pcyc
  function automatic logic [7:0] sbyte(input logic [1:0] c, input int s);
    case (c)
      2'h0: return {3'h0, p1[s], p2[s], mf[s] | af[s], bp[s], ic[s]};
      2'h1: return {4'h0, af[s], s == 1, 1'b1, m66[s]};
      2'h2: return {1'b0, ctrl[10+s], ctrl[8+s], ctrl[6+s], ctrl[4+s], ctrl[2+s], ctrl[s], 1'b1};
      default: return 8'h07;
    endcase
  endfunction : sbyte
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    ahb(1'b0, 32'(`HPC_CTRL_OFF), 32'h0, rd);
    chk(rd, 32'h0, "ctrl reset");
    for (int i = 0; i < 4; i++) begin
      pcyc(tab[i][2], tab[i][1], tab[i][0]);
      ahb(1'b0, 32'(`HPC_STAT_OFF), 32'h0, rd);
      chk(rd[2:0], mexp[i], "mode");
      if (i == 1) chk({si_oe, si_o}, 2'h3, "nand out");
      if (i == 2) chk({si_oe, pwi, att}, 5'h0, "tri pins");
    end
    chk(rd[5:4], 2'h3, "straps");
    $display("test modes done");
    ahb(1'b1, 32'(`HPC_CTRL_OFF), {20'h0, ctrl}, rd);
    for (int c = 0; c < 4; c++) begin
      mdl.frame(2'(c), 16'hC3A5 ^ 16'(c), 100, got);
      chk(got[15:0], {sbyte(2'(c), 1), sbyte(2'(c), 0)}, "own bytes");
      chk(got[31:16], 16'hC3A5 ^ 16'(c), "cascade");
    end
    $display("test channels done");
    tst <= 1'b1; af <= 2'h2;
    repeat (6) @(posedge ref_clk);
    chk({pwi, att}, {ctrl[1:0], mf | af}, "indicators");
    $display("test indicators done");
    pg <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({si_oe, so_oe, so_o}, 3'h0, "link off");
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk(rd, 32'h0, "unmapped");
    $display("test power off done");
    summarize();
  end
endmodule : hpc_strap_sin_tb_top
